// ===== gdpc_top.sv
// Gate driver protection configuration register with overcurrent and supply guard logic
//
// Summary of operation
// [R1] Edge speed code selects 25 to 200 V/us
// [R2] Writing clear command clears latched faults
// [R3] Clear command bit always reads back zero
// [R4] Level select picks 34 V or 22 V
// [R5] Overvoltage acted on only while guard enabled
// [R6] Thermal warning drives fault pin when enabled
// [R7] Overcurrent must persist for selected filter time
// [R8] Retry wait is 5 ms or 500 ms
// [R9] Trip level selects 9 A or 13 A
// [R10] Mode: latch, retry, report only, ignore
// [R11] Back-EMF threshold 20 mV or 100 mV
// [R12] Low-side demag threshold 100 or 150 mA
// [R13] High-side demag threshold 100 or 150 mA
// [R14] Sync rectification only while its enable set
// [R15] Async rectification only while its enable set
// [R16] Sense gain code selects 0.24 to 1.92 V/A
// [R17] Config word at ACh, resets to 00228000h
// [R18] Software writes back reserved bit reset values
// [R19] Retry mode re-enables outputs after wait
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module gdpc_top #(
  parameter int WAIT_SHORT_CYCLES = gdpc_pkg::GDPC_WAIT_SHORT_CYC,
  parameter int WAIT_LONG_CYCLES  = gdpc_pkg::GDPC_WAIT_LONG_CYC
) (
  input  wire logic                  ref_clk,
  input  wire logic                  reset,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output var  logic [31:0]           prdata,
  output var  logic                  pready,
  output var  logic                  pslverr,
  input  wire logic                  overcurrent_detect,
  input  wire logic                  overvoltage_detect,
  input  wire logic                  thermal_warning,
  output var  gdpc_pkg::gdpc_analog_t analog_settings,
  output var  logic                  driver_enable,
  output var  logic                  sync_rect_active,
  output var  logic                  async_rect_active,
  output var  logic                  fault_output_low_active,
  output var  logic                  irq
);
  import gdpc_pkg::*;

  typedef enum logic [2:0] {
    GDPC_ST_RUN     = 3'b001,
    GDPC_ST_LATCHED = 3'b010,
    GDPC_ST_WAIT    = 3'b100
  } gdpc_oc_state_t;

  gdpc_cfg_t              config_word;
  gdpc_oc_state_t         oc_state;
  gdpc_oc_state_t         next_oc_state;
  logic [GDPC_FILT_W-1:0] filt_cnt;
  logic [GDPC_WAIT_W-1:0] wait_cnt;
  logic [GDPC_IRQ_W-1:0]  irq_status;
  logic [GDPC_IRQ_W-1:0]  irq_mask;
  logic                   oc_reported;
  logic                   ov_seen;
  logic                   thermal_d;

  // APB decode
  wire logic              setup_phase = psel & ~penable;
  wire logic              access_done = psel & penable & pready;
  wire logic              wr_done     = access_done & pwrite;
  wire logic              hit_config  = (paddr == GDPC_ADDR_CONFIG);
  wire logic              hit_stat    = (paddr == GDPC_ADDR_IRQ_STAT);
  wire logic              hit_mask    = (paddr == GDPC_ADDR_IRQ_MASK);
  wire logic              hit_faults  = (paddr == GDPC_ADDR_FAULTS);
  wire logic              hit_any     = hit_config | hit_stat | hit_mask | hit_faults;
  wire logic              wr_config   = wr_done & hit_config;
  wire logic              wr_stat     = wr_done & hit_stat;
  wire logic              wr_mask     = wr_done & hit_mask;
  wire gdpc_cfg_t         wr_word     = gdpc_cfg_t'(pwdata);

  // [R2] Clear command pulse
  wire logic              clear_cmd   = wr_config & wr_word.latched_fault_clear_cmd;

  // Overcurrent filtering; counter saturates so one trip per excursion
  wire logic [GDPC_FILT_W-1:0] filt_target =
    (config_word.overcurrent_filter_time == 2'h0) ? GDPC_FILT0_CYC :
    (config_word.overcurrent_filter_time == 2'h1) ? GDPC_FILT1_CYC :
    (config_word.overcurrent_filter_time == 2'h2) ? GDPC_FILT2_CYC : GDPC_FILT3_CYC;
  // [R7] Trip after full filter time
  wire logic              oc_confirm  = overcurrent_detect &
                                        (filt_cnt == filt_target - 5'h01);
  wire gdpc_oc_mode_t     oc_mode     = config_word.overcurrent_response_mode;
  // [R10] Ignore mode neither reports nor acts
  wire logic              oc_trip     = oc_confirm & (oc_mode != GDPC_OC_IGNORE);
  wire logic              oc_latch    = oc_trip & (oc_mode == GDPC_OC_LATCH);
  wire logic              oc_retry    = oc_trip & (oc_mode == GDPC_OC_RETRY);
  wire logic              oc_report   = oc_trip & (oc_mode == GDPC_OC_REPORT);

  // [R8] Retry wait selection
  wire logic [GDPC_WAIT_W-1:0] wait_load = config_word.overcurrent_wait_time ?
    GDPC_WAIT_W'(WAIT_LONG_CYCLES - 1) : GDPC_WAIT_W'(WAIT_SHORT_CYCLES - 1);
  wire logic              wait_end    = (oc_state == GDPC_ST_WAIT) &&
                                        (wait_cnt == {GDPC_WAIT_W{1'b0}});

  // [R5] Overvoltage only counts while guarded
  wire logic              ov_active   = overvoltage_detect &
                                        config_word.supply_overvoltage_guard_enable;
  wire logic              thermal_rise = thermal_warning & ~thermal_d;

  // [R6] Thermal warning reaches the fault pin only when enabled
  wire logic              thermal_shown = thermal_warning &
                                          config_word.thermal_warning_report_enable;
  wire logic              any_fault   = (next_oc_state != GDPC_ST_RUN) | oc_reported |
                                        ov_seen | ov_active | thermal_shown;

  // Interrupt events; set wins over a write-one clear in the same cycle
  wire logic [GDPC_IRQ_W-1:0] irq_events = {wait_end, thermal_rise, ov_active, oc_trip};
  wire logic [GDPC_IRQ_W-1:0] irq_clear  = wr_stat ? pwdata[GDPC_IRQ_W-1:0] : 4'h0;
  wire logic [GDPC_IRQ_W-1:0] next_irq_status = (irq_status & ~irq_clear) | irq_events;

  // Fault summary readable by software
  wire logic [31:0]       fault_word  = {27'h0, thermal_warning, ov_seen, oc_reported,
                                         oc_state == GDPC_ST_WAIT,
                                         oc_state == GDPC_ST_LATCHED};

  // [R3] Clear command never stored, reads as zero
  wire logic [31:0]       read_mux    =
    hit_config ? 32'(config_word) :
    hit_stat   ? {28'h0, irq_status} :
    hit_mask   ? {28'h0, irq_mask} :
    hit_faults ? fault_word : 32'h0;

  // Decoded analog settings
  gdpc_analog_t next_analog;
  always_comb begin
    next_analog = '0;
    // [R1] Edge speed decode
    case (config_word.output_edge_speed)
      2'h0:    next_analog.edge_speed_v_per_us = GDPC_EDGE_V0;
      2'h1:    next_analog.edge_speed_v_per_us = GDPC_EDGE_V1;
      2'h2:    next_analog.edge_speed_v_per_us = GDPC_EDGE_V2;
      default: next_analog.edge_speed_v_per_us = GDPC_EDGE_V3;
    endcase
    // [R4] Overvoltage trip level
    next_analog.overvoltage_trip_v = config_word.supply_overvoltage_level_select ?
                                     GDPC_OV_LOW_V : GDPC_OV_HIGH_V;
    // [R9] Overcurrent trip level
    next_analog.overcurrent_trip_a = config_word.overcurrent_trip_level ?
                                     GDPC_OC_HIGH_A : GDPC_OC_LOW_A;
    // [R11] Back-EMF threshold
    next_analog.back_emf_threshold_mv = config_word.back_emf_compare_threshold ?
                                        GDPC_BEMF_HIGH_MV : GDPC_BEMF_LOW_MV;
    // [R12] Low-side demag threshold
    next_analog.demag_low_side_ma = config_word.demag_threshold_low_side ?
                                    GDPC_DEMAG_HIGH_MA : GDPC_DEMAG_LOW_MA;
    // [R13] High-side demag threshold
    next_analog.demag_high_side_ma = config_word.demag_threshold_high_side ?
                                     GDPC_DEMAG_HIGH_MA : GDPC_DEMAG_LOW_MA;
    // [R16] Sense gain decode
    case (config_word.current_sense_gain_select)
      2'h0:    next_analog.sense_gain_mv_per_a = GDPC_GAIN_0;
      2'h1:    next_analog.sense_gain_mv_per_a = GDPC_GAIN_1;
      2'h2:    next_analog.sense_gain_mv_per_a = GDPC_GAIN_2;
      default: next_analog.sense_gain_mv_per_a = GDPC_GAIN_3;
    endcase
  end

  // Overcurrent response state machine
  always_comb begin
    next_oc_state = oc_state;
    case (oc_state)
      GDPC_ST_RUN: begin
        if (oc_latch) begin
          next_oc_state = GDPC_ST_LATCHED;
        end else if (oc_retry) begin
          next_oc_state = GDPC_ST_WAIT;
        end
      end
      GDPC_ST_LATCHED: begin
        // [R2] Clear releases latch unless a new trip lands this cycle
        if (clear_cmd && !oc_latch) begin
          next_oc_state = GDPC_ST_RUN;
        end
      end
      GDPC_ST_WAIT: begin
        // [R19] Automatic return after the wait
        if (wait_end) begin
          next_oc_state = GDPC_ST_RUN;
        end
      end
      default: next_oc_state = GDPC_ST_RUN;
    endcase
  end

  // APB response: one wait-free access phase, data registered at setup
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= setup_phase;
      pslverr <= setup_phase & ~hit_any;
      prdata  <= (setup_phase & ~pwrite) ? read_mux : 32'h0;
    end
  end

  // Configuration word; reserved bits are stored as written
  always_ff @(posedge ref_clk) begin
    // [R17] Reset value of the configuration word
    if (reset) begin
      config_word <= gdpc_cfg_t'(GDPC_CONFIG_RESET);
    end else if (wr_config) begin
      config_word                         <= wr_word;
      // [R3] Command bit self-clears
      config_word.latched_fault_clear_cmd <= 1'b0;
    end
  end

  // Interrupt status and mask
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq_status <= GDPC_IRQ_RESET;
      irq_mask   <= GDPC_IRQ_RESET;
      irq        <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq_mask   <= wr_mask ? pwdata[GDPC_IRQ_W-1:0] : irq_mask;
      irq        <= |(next_irq_status & (wr_mask ? pwdata[GDPC_IRQ_W-1:0] : irq_mask));
    end
  end

  // Overcurrent filter counter and retry wait timer
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      filt_cnt <= {GDPC_FILT_W{1'b0}};
      wait_cnt <= {GDPC_WAIT_W{1'b0}};
      oc_state <= GDPC_ST_RUN;
    end else begin
      // [R7] Any gap in the condition restarts filtering
      filt_cnt <= !overcurrent_detect ? {GDPC_FILT_W{1'b0}} :
                  (filt_cnt >= filt_target) ? filt_cnt : filt_cnt + 5'h01;
      // [R8] Load wait on retry entry, then count down
      if (oc_state == GDPC_ST_RUN && oc_retry) begin
        wait_cnt <= wait_load;
      end else if (oc_state == GDPC_ST_WAIT && !wait_end) begin
        wait_cnt <= wait_cnt - 23'h000001;
      end
      oc_state <= next_oc_state;
    end
  end

  // Latched report flags; a new event wins over a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      oc_reported <= 1'b0;
      ov_seen     <= 1'b0;
      thermal_d   <= 1'b0;
    end else begin
      // [R10] Report-only mode flags without acting
      oc_reported <= oc_report | (oc_reported & ~clear_cmd);
      // [R2] Clear wipes the latched overvoltage flag
      ov_seen     <= ov_active | (ov_seen & ~clear_cmd);
      thermal_d   <= thermal_warning;
    end
  end

  // Registered outputs toward the power stage
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      analog_settings         <= '0;
      driver_enable           <= 1'b0;
      sync_rect_active        <= 1'b0;
      async_rect_active       <= 1'b0;
      fault_output_low_active <= 1'b1;
    end else begin
      analog_settings         <= next_analog;
      // [R10] Latch and retry modes take the outputs down
      driver_enable           <= (next_oc_state == GDPC_ST_RUN) & ~ov_active;
      // [R14] Synchronous rectification gated by its enable
      sync_rect_active        <= config_word.sync_rectification_enable &
                                 (next_oc_state == GDPC_ST_RUN) & ~ov_active;
      // [R15] Asynchronous rectification gated by its enable
      async_rect_active       <= config_word.async_rectification_enable &
                                 (next_oc_state == GDPC_ST_RUN) & ~ov_active;
      // [R6] Pin is low while any reported fault stands
      fault_output_low_active <= ~any_fault;
    end
  end

endmodule : gdpc_top
`default_nettype wire

// ===== gdpc_pkg.sv
// Constants, field layouts and types for the gate driver protection configuration block
`default_nettype none
package gdpc_pkg;

  // Register byte addresses
  localparam logic [7:0]  GDPC_ADDR_CONFIG   = 8'hAC;
  localparam logic [7:0]  GDPC_ADDR_IRQ_STAT = 8'hB0;
  localparam logic [7:0]  GDPC_ADDR_IRQ_MASK = 8'hB4;
  localparam logic [7:0]  GDPC_ADDR_FAULTS   = 8'hB8;

  // Reset values
  localparam logic [31:0] GDPC_CONFIG_RESET  = 32'h0022_8000;
  localparam logic [3:0]  GDPC_IRQ_RESET     = 4'h0;

  // Overcurrent response modes
  typedef enum logic [1:0] {
    GDPC_OC_LATCH  = 2'h0,
    GDPC_OC_RETRY  = 2'h1,
    GDPC_OC_REPORT = 2'h2,
    GDPC_OC_IGNORE = 2'h3
  } gdpc_oc_mode_t;

  // Layout of the configuration word, bit 31 first
  typedef struct packed {
    logic          parity;
    logic [2:0]    rsvd_30_28;
    logic [1:0]    output_edge_speed;
    logic [1:0]    rsvd_25_24;
    logic          latched_fault_clear_cmd;
    logic [2:0]    rsvd_22_20;
    logic          supply_overvoltage_level_select;
    logic          supply_overvoltage_guard_enable;
    logic          rsvd_17;
    logic          thermal_warning_report_enable;
    logic [1:0]    rsvd_15_14;
    logic [1:0]    overcurrent_filter_time;
    logic          overcurrent_wait_time;
    logic          overcurrent_trip_level;
    gdpc_oc_mode_t overcurrent_response_mode;
    logic          back_emf_compare_threshold;
    logic          rsvd_6;
    logic          demag_threshold_low_side;
    logic          demag_threshold_high_side;
    logic          sync_rectification_enable;
    logic          async_rectification_enable;
    logic [1:0]    current_sense_gain_select;
  } gdpc_cfg_t;

  // Decoded settings handed to the analog section
  typedef struct packed {
    logic [7:0]  edge_speed_v_per_us;
    logic [5:0]  overvoltage_trip_v;
    logic [3:0]  overcurrent_trip_a;
    logic [6:0]  back_emf_threshold_mv;
    logic [7:0]  demag_low_side_ma;
    logic [7:0]  demag_high_side_ma;
    logic [10:0] sense_gain_mv_per_a;
  } gdpc_analog_t;

  // Interrupt status bit positions
  localparam int          GDPC_IRQ_W         = 4;
  localparam int          GDPC_IRQ_OC_TRIP   = 0;
  localparam int          GDPC_IRQ_OV_TRIP   = 1;
  localparam int          GDPC_IRQ_THERMAL   = 2;
  localparam int          GDPC_IRQ_RETRY_END = 3;

  // Decode tables
  localparam logic [7:0]  GDPC_EDGE_V0       = 8'h19;
  localparam logic [7:0]  GDPC_EDGE_V1       = 8'h32;
  localparam logic [7:0]  GDPC_EDGE_V2       = 8'h7D;
  localparam logic [7:0]  GDPC_EDGE_V3       = 8'hC8;
  localparam logic [5:0]  GDPC_OV_HIGH_V     = 6'h22;
  localparam logic [5:0]  GDPC_OV_LOW_V      = 6'h16;
  localparam logic [3:0]  GDPC_OC_LOW_A      = 4'h9;
  localparam logic [3:0]  GDPC_OC_HIGH_A     = 4'hD;
  localparam logic [6:0]  GDPC_BEMF_LOW_MV   = 7'h14;
  localparam logic [6:0]  GDPC_BEMF_HIGH_MV  = 7'h64;
  localparam logic [7:0]  GDPC_DEMAG_LOW_MA  = 8'h64;
  localparam logic [7:0]  GDPC_DEMAG_HIGH_MA = 8'h96;
  localparam logic [10:0] GDPC_GAIN_0        = 11'h0F0;
  localparam logic [10:0] GDPC_GAIN_1        = 11'h1E0;
  localparam logic [10:0] GDPC_GAIN_2        = 11'h3C0;
  localparam logic [10:0] GDPC_GAIN_3        = 11'h780;

  // Timing
  localparam int          GDPC_CLK_PERIOD_NS = 100;
  localparam int          GDPC_NS_PER_MS     = 1_000_000;
  localparam int          GDPC_FILT0_NS      = 200;
  localparam int          GDPC_FILT1_NS      = 600;
  localparam int          GDPC_FILT2_NS      = 1200;
  localparam int          GDPC_FILT3_NS      = 1600;
  localparam int          GDPC_FILT_W        = 5;
  localparam logic [4:0]  GDPC_FILT0_CYC     =
    5'((GDPC_FILT0_NS + GDPC_CLK_PERIOD_NS - 1) / GDPC_CLK_PERIOD_NS);
  localparam logic [4:0]  GDPC_FILT1_CYC     =
    5'((GDPC_FILT1_NS + GDPC_CLK_PERIOD_NS - 1) / GDPC_CLK_PERIOD_NS);
  localparam logic [4:0]  GDPC_FILT2_CYC     =
    5'((GDPC_FILT2_NS + GDPC_CLK_PERIOD_NS - 1) / GDPC_CLK_PERIOD_NS);
  localparam logic [4:0]  GDPC_FILT3_CYC     =
    5'((GDPC_FILT3_NS + GDPC_CLK_PERIOD_NS - 1) / GDPC_CLK_PERIOD_NS);
  localparam int          GDPC_WAIT_SHORT_MS = 5;
  localparam int          GDPC_WAIT_LONG_MS  = 500;
  localparam int          GDPC_WAIT_W        = 23;
  localparam int          GDPC_WAIT_SHORT_CYC =
    GDPC_WAIT_SHORT_MS * (GDPC_NS_PER_MS / GDPC_CLK_PERIOD_NS);
  localparam int          GDPC_WAIT_LONG_CYC  =
    GDPC_WAIT_LONG_MS * (GDPC_NS_PER_MS / GDPC_CLK_PERIOD_NS);

endpackage : gdpc_pkg
`default_nettype wire

// ===== gdpc_asserts.sv
// Concurrent checks on the ports of the gate driver protection block
`timescale 1ns/1ns
`default_nettype none
module gdpc_asserts #(
  parameter int WAIT_SHORT_CYCLES = 20,
  parameter int WAIT_LONG_CYCLES  = 50
) (
  input wire logic                   ref_clk,
  input wire logic                   reset,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [7:0]             paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic                   overcurrent_detect,
  input wire logic                   overvoltage_detect,
  input wire logic                   thermal_warning,
  input wire gdpc_pkg::gdpc_analog_t analog_settings,
  input wire logic                   driver_enable,
  input wire logic                   sync_rect_active,
  input wire logic                   async_rect_active,
  input wire logic                   fault_output_low_active,
  input wire logic                   irq
);
  import gdpc_pkg::*;
  // Shadow of the config word and run counters for the timing checks
  gdpc_cfg_t   sh;
  int unsigned low_cnt;
  logic [4:0]  oc_run;
  wire logic        wr_cfg = psel && penable && pready && pwrite && paddr == GDPC_ADDR_CONFIG;
  wire logic [31:0] edge_tbl = {GDPC_EDGE_V3, GDPC_EDGE_V2, GDPC_EDGE_V1, GDPC_EDGE_V0};
  wire logic [43:0] gain_tbl = {GDPC_GAIN_3, GDPC_GAIN_2, GDPC_GAIN_1, GDPC_GAIN_0};
  wire logic [19:0] filt_tbl = {GDPC_FILT3_CYC, GDPC_FILT2_CYC, GDPC_FILT1_CYC, GDPC_FILT0_CYC};
  wire logic [4:0]  filt_need = filt_tbl[5*sh.overcurrent_filter_time +: 5];
  // Saturate so a stuck detector cannot wrap back under the filter time
  wire logic [4:0]  next_oc_run = !overcurrent_detect ? 5'h00 : (&oc_run ? oc_run : oc_run + 5'h01);
  always_ff @(posedge ref_clk) begin
    sh      <= reset ? gdpc_cfg_t'(GDPC_CONFIG_RESET) : (wr_cfg ? gdpc_cfg_t'(pwdata) : sh);
    low_cnt <= (reset || driver_enable) ? 0 : low_cnt + 1;
    oc_run  <= reset ? 5'h00 : next_oc_run;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  AST_PREADY_NEXT: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_CLR_READS_ZERO: assert property (pready && !pwrite && paddr == GDPC_ADDR_CONFIG |-> !prdata[23])
    else $error("clear command reads one");
  AST_EDGE_DECODE: assert property (wr_cfg |=> ##1
    analog_settings.edge_speed_v_per_us == edge_tbl[8*sh.output_edge_speed +: 8]) else $error("edge speed");
  AST_GAIN_DECODE: assert property (wr_cfg |=> ##1
    analog_settings.sense_gain_mv_per_a == gain_tbl[11*sh.current_sense_gain_select +: 11]) else $error("gain");
  AST_OV_GUARD: assert property ((sh.supply_overvoltage_guard_enable && overvoltage_detect)[*3]
    |-> !fault_output_low_active) else $error("guarded overvoltage not flagged");
  AST_THERMAL: assert property ((sh.thermal_warning_report_enable && thermal_warning)[*3]
    |-> !fault_output_low_active) else $error("thermal warning not flagged");
  AST_SYNC_OFF: assert property (!sh.sync_rectification_enable [*2] |-> !sync_rect_active)
    else $error("sync rectification while disabled");
  AST_ASYNC_OFF: assert property (!sh.async_rectification_enable [*2] |-> !async_rect_active)
    else $error("async rectification while disabled");
  AST_OC_NOT_EARLY: assert property ($fell(driver_enable) && !sh.supply_overvoltage_guard_enable
    |-> oc_run >= filt_need || $past(oc_run) >= filt_need) else $error("trip before filter time");
  AST_RETRY_WAIT: assert property ($rose(driver_enable) && sh.overcurrent_response_mode == GDPC_OC_RETRY
    && low_cnt > 1 |-> low_cnt == (sh.overcurrent_wait_time ? WAIT_LONG_CYCLES : WAIT_SHORT_CYCLES))
    else $error("retry wait length");
  AST_CLEAR_RELEASE: assert property (wr_cfg && pwdata[23] && pwdata[9:8] == 2'h0 && !overcurrent_detect
    && sh.overcurrent_response_mode == GDPC_OC_LATCH && !sh.supply_overvoltage_guard_enable
    && !pwdata[18] |-> ##[1:3] driver_enable) else $error("clear did not release driver");
endmodule : gdpc_asserts
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the gate driver protection block
`timescale 1ns/1ns
`default_nettype none
module tb;
  import gdpc_pkg::*;
  localparam int WS = 20;
  localparam int WL = 50;
  localparam logic [7:0]  ET [4] = '{GDPC_EDGE_V0, GDPC_EDGE_V1, GDPC_EDGE_V2, GDPC_EDGE_V3};
  localparam logic [10:0] GT [4] = '{GDPC_GAIN_0, GDPC_GAIN_1, GDPC_GAIN_2, GDPC_GAIN_3};
  logic         ref_clk, reset, psel, penable, pwrite, pready, pslverr, oc, ov, tw;
  logic         driver_enable, sync_rect_active, async_rect_active, fault_output_low_active, irq;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, seed, d;
  gdpc_analog_t an, ea;
  logic [32:0]  exp_q[$];
  int           error_cnt, check_count, i, c;
  gdpc_top #(.WAIT_SHORT_CYCLES(WS), .WAIT_LONG_CYCLES(WL)) i_gdpc_top (.ref_clk(ref_clk),
    .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .overcurrent_detect(oc),
    .overvoltage_detect(ov), .thermal_warning(tw), .analog_settings(an), .driver_enable(driver_enable),
    .sync_rect_active(sync_rect_active), .async_rect_active(async_rect_active),
    .fault_output_low_active(fault_output_low_active), .irq(irq));
  always #50 ref_clk = ~ref_clk;
  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  // One APB transfer, then one idle cycle so no signal is driven twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= v;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin @(posedge ref_clk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin error_cnt++; tally_and_finish(); end
    psel <= 1'b0; penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd
  function automatic logic [31:0] cw(input logic [31:0] f);
    return GDPC_CONFIG_RESET | f;
  endfunction : cw
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic pulse(input int n);
    oc <= 1'b1;
    cyc(n);
    oc <= 1'b0;
  endtask : pulse
  // Reads are compared at the edge that completes them, oldest note first
  always @(posedge ref_clk) begin
    if (psel && penable && pready === 1'b1 && pwrite === 1'b0) begin
      if (exp_q.size() == 0) check("read without note", 1, 0);
      else check("read", {pslverr, prdata}, exp_q.pop_front());
    end
  end
  initial begin
    ref_clk = 0; reset = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    oc = 0; ov = 0; tw = 0; seed = 32'd70; error_cnt = 0; check_count = 0;
    cyc(2);
    reset <= 1'b0;
    cyc(1);
    rd(GDPC_ADDR_CONFIG, {1'b0, GDPC_CONFIG_RESET});
    rd(GDPC_ADDR_IRQ_MASK, 33'h0);
    rd(8'hAE, {1'b1, 32'h0000_0000});
    $display("reset values done");
    for (i = 0; i < 4; i++) begin
      repeat (8) seed = lfsr(seed);
      d = cw(seed & 32'h8C8D_3FBF);
      d[27:26] = i[1:0];
      d[1:0] = i[1:0];
      apb(1'b1, GDPC_ADDR_CONFIG, d);
      cyc(1);
      ea = {ET[i], d[19] ? GDPC_OV_LOW_V : GDPC_OV_HIGH_V, d[10] ? GDPC_OC_HIGH_A : GDPC_OC_LOW_A,
        d[7] ? GDPC_BEMF_HIGH_MV : GDPC_BEMF_LOW_MV, d[5] ? GDPC_DEMAG_HIGH_MA : GDPC_DEMAG_LOW_MA,
        d[4] ? GDPC_DEMAG_HIGH_MA : GDPC_DEMAG_LOW_MA, GT[i]};
      check("analog", an, ea);
      check("rect", {sync_rect_active, async_rect_active}, d[3:2]);
      rd(GDPC_ADDR_CONFIG, {1'b0, d & 32'hFF7F_FFFF});
    end
    $display("decode done");
    apb(1'b1, GDPC_ADDR_IRQ_MASK, 32'h0000_0001);
    apb(1'b1, GDPC_ADDR_CONFIG, cw(32'h0000_1000));
    pulse(int'(GDPC_FILT1_CYC) - 1);
    cyc(3);
    check("short burst", {driver_enable, irq}, 2'b10);
    pulse(int'(GDPC_FILT1_CYC));
    cyc(3);
    check("latched", {driver_enable, fault_output_low_active, irq}, 3'b001);
    rd(GDPC_ADDR_FAULTS, 33'h1);
    rd(GDPC_ADDR_IRQ_STAT, 33'h1);
    apb(1'b1, GDPC_ADDR_IRQ_STAT, 32'h0000_0001);
    check("still latched", {driver_enable, irq}, 2'b00);
    apb(1'b1, GDPC_ADDR_CONFIG, cw(32'h0080_1000));
    cyc(1);
    check("cleared", {driver_enable, fault_output_low_active}, 2'b11);
    $display("latch done");
    apb(1'b1, GDPC_ADDR_IRQ_MASK, 32'h0000_0000);
    for (i = 0; i < 2; i++) begin
      apb(1'b1, GDPC_ADDR_CONFIG, cw(32'h0000_0100 | (i << 11)));
      pulse(2);
      c = 0;
      // Count low cycles, bounded so a stuck driver cannot hang the run
      repeat (200) begin
        @(posedge ref_clk);
        if (driver_enable === 1'b0) c++;
        else if (c > 0) break;
      end
      check("retry wait", c, (i == 1) ? WL : WS);
      cyc(2);
      check("after retry", {irq, fault_output_low_active}, 2'b01);
    end
    rd(GDPC_ADDR_IRQ_STAT, 33'h9);
    apb(1'b1, GDPC_ADDR_IRQ_STAT, 32'h0000_000F);
    $display("retry done");
    for (i = 2; i < 4; i++) begin
      apb(1'b1, GDPC_ADDR_CONFIG, cw(i << 8));
      pulse(4);
      cyc(3);
      check("mode", {driver_enable, fault_output_low_active}, {1'b1, i == 3});
      apb(1'b1, GDPC_ADDR_CONFIG, cw(32'h0080_0000 | (i << 8)));
    end
    $display("report modes done");
    ov <= 1'b1;
    tw <= 1'b1;
    apb(1'b1, GDPC_ADDR_CONFIG, cw(32'h0000_000C));
    cyc(3);
    check("unguarded", {fault_output_low_active, sync_rect_active, async_rect_active}, 3'b111);
    apb(1'b1, GDPC_ADDR_CONFIG, cw(32'h0004_000C));
    cyc(3);
    check("guarded", {fault_output_low_active, sync_rect_active}, 2'b00);
    ov <= 1'b0;
    apb(1'b1, GDPC_ADDR_CONFIG, cw(32'h0081_0000));
    cyc(3);
    check("thermal", fault_output_low_active, 1'b0);
    tw <= 1'b0;
    cyc(3);
    check("thermal gone", fault_output_low_active, 1'b1);
    $display("supply and thermal done");
    reset <= 1'b1;
    cyc(2);
    reset <= 1'b0;
    cyc(1);
    rd(GDPC_ADDR_CONFIG, {1'b0, GDPC_CONFIG_RESET});
    $display("second reset done");
    tally_and_finish();
  end
endmodule : tb
bind gdpc_top gdpc_asserts #(.WAIT_SHORT_CYCLES(WAIT_SHORT_CYCLES), .WAIT_LONG_CYCLES(WAIT_LONG_CYCLES))
  i_gdpc_asserts (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .overcurrent_detect(overcurrent_detect),
  .overvoltage_detect(overvoltage_detect), .thermal_warning(thermal_warning),
  .analog_settings(analog_settings), .driver_enable(driver_enable),
  .sync_rect_active(sync_rect_active), .async_rect_active(async_rect_active),
  .fault_output_low_active(fault_output_low_active), .irq(irq));
`default_nettype wire
